// >>> rtl/serial_eeprom_slave.v
// two-wire slave of a byte-organised eeprom with page buffer and timed program
// assumes scl and sda arrive asynchronously and sda is pulled up outside
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_defines.vh"
// What this block does
// - sample data on serial clock rise, change driven data after its fall
// - start is data falling while clock high; every transaction begins with one
// - stop is data rising while clock high; after read returns to standby
// - stop after write data ends intake, runs program cycle, then standby
// - words are 8 bits; receiver drives zero on ninth clock
// - write: acknowledge every word; read: acknowledge only the address word
// - after read byte release; master zero ack gets next byte
// - no ack and no stop: keep line released, send nothing
// - address word: type code, three select bits upper first, direction bit
// - acknowledge only on type and select match, else back to standby
// - byte write: address word, two address bytes, one data byte, all acked
// - ignore clock and data during the program cycle
// - extra data bytes make a page write of up to 64 bytes
// - in-page offset wraps to page start, overwriting buffered data
// - write address word during program cycle gets no ack, after it does
// - counter holds last address plus one; read word returns that byte msb first
// - counter wraps to zero after last read address, in-page after write
// - random read: dummy write of address then repeated start and read
// - program cycle ends within 10 ms, or 15 ms at the low supply range
// - sequential read wraps to zero past the last address and continues
module serial_eeprom_slave #(
  parameter ADDR_W = 15,
  parameter [3:0] TYPE_CODE = 4'h6, // arbitrary value, not any real type code
  parameter PROG_CYCLES = `PROG_CYCLES_HIGH
) (
  input wire clk,
  input wire sys_rst,
  input wire scl,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire [2:0] chip_select_straps,
  input wire write_protect,
  output wire program_busy
);
  localparam PG = `PAGE_BITS;
  // protocol states
  localparam [2:0] ST_IDLE = 3'h0; // standby, waiting for a start
  localparam [2:0] ST_DEVADR = 3'h1; // taking the address word
  localparam [2:0] ST_ADRHI = 3'h2; // taking the upper memory address byte
  localparam [2:0] ST_ADRLO = 3'h3; // taking the lower memory address byte
  localparam [2:0] ST_WDATA = 3'h4; // taking write data into the page buffer
  localparam [2:0] ST_RDATA = 3'h5; // shifting a read byte out
  localparam [2:0] ST_RACK = 3'h6; // waiting for the master's answer
  localparam [2:0] ST_IGNORE = 3'h7; // released, waiting for start or stop
  // 24 bits cover the count of either supply range at 100 MHz
  localparam [23:0] PROG_LEN = PROG_CYCLES[23:0];

  // synchronised pins and their history
  wire scl_s;
  wire sda_s;
  wire wp_s;
  wire [2:0] straps_s;
  reg scl_d;
  reg sda_d;
  // word engine
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg ack_phase;
  reg [ADDR_W-1:0] addr_cnt;
  reg [ADDR_W-1:0] wr_base;
  // page buffer and program cycle
  reg [7:0] page_buf [0:(1<<PG)-1];
  reg [(1<<PG)-1:0] page_valid;
  reg prog_run;
  reg [23:0] prog_cnt;
  reg [PG:0] flush_idx;
  reg [7:0] addr_hi;
  // array read data and decoded bus events
  wire [7:0] rd_data;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [ADDR_W-1:0] flush_addr;
  wire flush_en;
  wire prot_hit;

  // bus lines reset to their idle high level so no false edge follows reset
  pin_sync #(.RESET_VAL(1'b1)) u_scl (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(scl),
    .sync_out(scl_s)
  );
  pin_sync #(.RESET_VAL(1'b1)) u_sda (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(sda_in),
    .sync_out(sda_s)
  );

  // strap and protect pins are board levels; two flops keep them out of meta
  pin_sync #(.RESET_VAL(1'b0)) u_wp (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(write_protect),
    .sync_out(wp_s)
  );
  pin_sync #(.RESET_VAL(1'b0)) u_strap0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(chip_select_straps[0]),
    .sync_out(straps_s[0])
  );
  pin_sync #(.RESET_VAL(1'b0)) u_strap1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(chip_select_straps[1]),
    .sync_out(straps_s[1])
  );
  pin_sync #(.RESET_VAL(1'b0)) u_strap2 (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(chip_select_straps[2]),
    .sync_out(straps_s[2])
  );

  // edge history of synchronised lines
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign program_busy = prog_run;

  // protected region is the top eighth: upper three address bits all ones
  function is_protected;
    input [ADDR_W-1:0] a;
    begin
      is_protected = &a[ADDR_W-1:ADDR_W-3];
    end
  endfunction

  // in-page increment keeps the page bits
  function [ADDR_W-1:0] page_inc;
    input [ADDR_W-1:0] a;
    begin
      page_inc = {a[ADDR_W-1:PG], a[PG-1:0] + {{(PG-1){1'b0}}, 1'b1}};
    end
  endfunction

  // address word accepted only when type code and strap levels both match
  function sel_match;
    input [7:0] w;
    input [2:0] pins;
    begin
      sel_match = (w[`DEV_TYPE_MSB:`DEV_TYPE_LSB] == TYPE_CODE) &&
        (w[`DEV_SEL_MSB:`DEV_SEL_LSB] == pins);
    end
  endfunction

  // flush walks the buffer one byte per clock while the program timer runs
  assign flush_addr = {wr_base[ADDR_W-1:PG], flush_idx[PG-1:0]};
  assign prot_hit = wp_s & is_protected(flush_addr);
  assign flush_en = prog_run & ~flush_idx[PG] & page_valid[flush_idx[PG-1:0]] & ~prot_hit;

  array_store #(.ADDR_W(ADDR_W)) u_store (
    .clk(clk),
    .wr_en(flush_en),
    .wr_addr(flush_addr),
    .wr_data(page_buf[flush_idx[PG-1:0]]),
    .rd_addr(addr_cnt),
    .rd_data(rd_data)
  );

  // program cycle timer; bus is deaf while it runs
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_run <= 1'b0;
      prog_cnt <= 24'h000000;
      flush_idx <= {(PG+1){1'b0}};
    end else if (prog_run) begin
      if (!flush_idx[PG]) begin
        flush_idx <= flush_idx + {{PG{1'b0}}, 1'b1};
      end
      if (prog_cnt == PROG_LEN - 24'h000001) begin
        prog_run <= 1'b0;
      end
      prog_cnt <= prog_cnt + 24'h000001;
    end else if (stop_cond && state == ST_WDATA && |page_valid && !ack_phase) begin
      prog_run <= 1'b1;
      prog_cnt <= 24'h000000;
      flush_idx <= {(PG+1){1'b0}};
    end
  end

  // page buffer written as data bytes arrive
  always @(posedge clk) begin
    if (!prog_run && state == ST_WDATA && scl_rise && bit_cnt == 4'h7 && !ack_phase) begin
      page_buf[addr_cnt[PG-1:0]] <= {shreg[6:0], sda_s};
    end
  end

  // main protocol engine
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
      addr_cnt <= {ADDR_W{1'b0}};
      wr_base <= {ADDR_W{1'b0}};
      page_valid <= {(1<<PG){1'b0}};
      addr_hi <= 8'h00;
    end else if (prog_run) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
      if (flush_idx[PG]) begin
        page_valid <= {(1<<PG){1'b0}};
      end
    end else if (start_cond) begin
      state <= ST_DEVADR;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_IGNORE: begin
          sda_oe <= 1'b0;
        end
        ST_DEVADR, ST_ADRHI, ST_ADRLO, ST_WDATA: begin
          if (!ack_phase) begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `BITS_PER_WORD) begin
              bit_cnt <= 4'h0;
              case (state)
                ST_DEVADR: begin
                  if (sel_match(shreg, straps_s)) begin
                    ack_phase <= 1'b1;
                    sda_oe <= 1'b1;
                  end else begin
                    state <= ST_IDLE;
                  end
                end
                ST_ADRHI: begin
                  addr_hi <= shreg;
                  ack_phase <= 1'b1;
                  sda_oe <= 1'b1;
                end
                ST_ADRLO: begin
                  // unused upper address bits dropped
                  addr_cnt <= {addr_hi[ADDR_W-9:0], shreg};
                  wr_base <= {addr_hi[ADDR_W-9:0], shreg};
                  page_valid <= {(1<<PG){1'b0}};
                  ack_phase <= 1'b1;
                  sda_oe <= 1'b1;
                end
                default: begin
                  page_valid[addr_cnt[PG-1:0]] <= 1'b1;
                  addr_cnt <= page_inc(addr_cnt);
                  ack_phase <= 1'b1;
                  sda_oe <= 1'b1;
                end
              endcase
            end
          end else if (scl_fall) begin
            // ninth clock done: release and move on
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
            case (state)
              ST_DEVADR: begin
                if (shreg[`DEV_DIR_BIT]) begin
                  state <= ST_RDATA;
                  shreg <= rd_data;
                  sda_oe <= ~rd_data[7];
                  bit_cnt <= 4'h0;
                end else begin
                  state <= ST_ADRHI;
                end
              end
              ST_ADRHI: state <= ST_ADRLO;
              default: state <= ST_WDATA;
            endcase
          end
        end
        ST_RDATA: begin
          // shift out after each falling edge, msb first
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              sda_oe <= 1'b0;
              bit_cnt <= 4'h0;
              addr_cnt <= addr_cnt + {{(ADDR_W-1){1'b0}}, 1'b1};
              state <= ST_RACK;
            end else begin
              sda_oe <= ~shreg[6];
              shreg <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            ack_phase <= ~sda_s;
          end else if (scl_fall) begin
            if (ack_phase) begin
              state <= ST_RDATA;
              shreg <= rd_data;
              sda_oe <= ~rd_data[7];
              ack_phase <= 1'b0;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // serial_eeprom_slave
`default_nettype wire

// >>> rtl/serial_eeprom_defines.vh
// constants for the two-wire eeprom slave interface
// assumes a 100 MHz system clock; included by bare name
`ifndef SERIAL_EEPROM_DEFINES_VH
`define SERIAL_EEPROM_DEFINES_VH
`define CLK_PERIOD_NS 10
// internal_program_time in ms at upper and lowest supply ranges
`define PROG_TIME_MS_HIGH 10
`define PROG_TIME_MS_LOW 15
`define PROG_CYCLES_HIGH ((`PROG_TIME_MS_HIGH * 1000000) / `CLK_PERIOD_NS)
`define PROG_CYCLES_LOW ((`PROG_TIME_MS_LOW * 1000000) / `CLK_PERIOD_NS)
// device address word fields
`define DEV_TYPE_MSB 7
`define DEV_TYPE_LSB 4
`define DEV_SEL_MSB 3
`define DEV_SEL_LSB 1
`define DEV_DIR_BIT 0
`define BITS_PER_WORD 4'h8
`define PAGE_BITS 6
`endif

// >>> rtl/pin_sync.v
// two-flop synchroniser for one asynchronous level
// assumes the input comes from outside the clk domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire clk,
  input wire sys_rst,
  input wire async_in,
  output reg sync_out
);
  reg meta;

  // first stage feeds only the second stage
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> rtl/array_store.v
// byte memory standing in for the nonvolatile array
// assumes one write port and one registered read port on clk
`timescale 1ns/1ps
`default_nettype none
module array_store #(
  parameter ADDR_W = 15
) (
  input wire clk,
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [ADDR_W-1:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:(1<<ADDR_W)-1];

  // read registered so the byte is ready a cycle after the address settles
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // array_store
`default_nettype wire

// >>> verification/eeprom_props.sv
// checker of the eeprom slave port behaviour
// bound onto serial_eeprom_slave; PROG_CYCLES is handed on by the bind
`timescale 1ns/1ps
`default_nettype none
module eeprom_props #(
  parameter PROG_CYCLES = 400
) (
  input wire clk,
  input wire sys_rst,
  input wire scl,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [2:0] chip_select_straps,
  input wire write_protect,
  input wire program_busy
);
  int cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // length of the running program cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cnt <= 0;
    else cnt <= program_busy ? cnt + 1 : 0;
  end
  // bus conditions seen on the raw pins
  sequence s_start;
    scl && $past(scl) && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda_in);
  endsequence
  AST_OE_MOVE: assert property ($changed(sda_oe) |-> !scl)
    else $error("drive moved with scl high");
  AST_START_QUIET: assert property (s_start |=> !sda_oe [*8])
    else $error("drive too soon after start");
  AST_STOP_QUIET: assert property (s_stop |=> !sda_oe [*8])
    else $error("drive after stop");
  AST_OD: assert property (sda_oe |-> !sda_out && !sda_in)
    else $error("drive not low");
  AST_BUSY_AT_STOP: assert property ($rose(program_busy) |-> scl && sda_in)
    else $error("program began off a stop");
  AST_BUSY_QUIET: assert property (program_busy |-> !sda_oe)
    else $error("answered while busy");
  AST_BUSY_MAX: assert property (program_busy |-> cnt < PROG_CYCLES + 2)
    else $error("program cycle too long");
  AST_BUSY_MIN: assert property ($fell(program_busy) |-> cnt >= PROG_CYCLES - 1)
    else $error("program cycle cut short");
endmodule // eeprom_props
bind serial_eeprom_slave eeprom_props #(.PROG_CYCLES(PROG_CYCLES)) props_u (
  .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .chip_select_straps(chip_select_straps),
  .write_protect(write_protect), .program_busy(program_busy));
`default_nettype wire

// >>> verification/bus_master.sv
// two-wire bus master model, 125 ns bit period
// assumes the bench resolves the data wire with a pull-up and hands over clk
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam realtime Q = 31.25;
  // idle bus: clock high, line released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data moves mid-low, so a slow slave release still settles first
  task automatic bit_cyc(input logic v, output logic s);
    #Q sda_low = !v;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
  endtask
  task automatic start_c();
    // step 1 ns off a rising clk edge: quarter steps then never meet one
    @(posedge clk);
    #1;
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop_c();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
  endtask
  // word msb first, line released on the ninth clock
  task automatic put_byte(input logic [7:0] b, output logic [7:0] ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
    bit_cyc(1'b1, s);
    ack = {7'h0, s};
  endtask
  // word taken with line released, then answered
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, b[i]);
    bit_cyc(ack, s);
  endtask
endmodule // bus_master
`default_nettype wire

// >>> verification/test_serial_eeprom_slave.sv
// self-checking bench of the eeprom slave driven by a bus master model
// assumes design, checker and master model compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_slave;
  localparam int PROG = 400;
  localparam logic [3:0] TC = 4'h5; // arbitrary type code
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] straps = 3'h5;
  logic wp = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, busy;
  logic [7:0] a, b;
  logic [7:0] q[$];
  wire sda;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // open-drain wire with pull-up
  assign sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  serial_eeprom_slave #(.TYPE_CODE(TC), .PROG_CYCLES(PROG)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_straps(straps), .write_protect(wp), .program_busy(busy));
  bus_master m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  initial forever #5 clk = ~clk;
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [7:0] dw(input logic r);
    return {TC, straps, r};
  endfunction
  // address word alone, then stop
  task automatic poll(input logic [7:0] w, input logic [7:0] e);
    m.start_c();
    m.put_byte(w, a);
    chk("poll ack", e, a);
    m.stop_c();
  endtask
  task automatic set_addr(input logic [15:0] ad);
    m.start_c();
    m.put_byte(dw(1'b0), a);
    chk("dev ack", 8'h0, a);
    m.put_byte(ad[15:8], a);
    chk("hi ack", 8'h0, a);
    m.put_byte(ad[7:0], a);
    chk("lo ack", 8'h0, a);
  endtask
  // polling inside the program cycle is refused, after it answered
  task automatic wr(input logic [15:0] ad);
    set_addr(ad);
    foreach (q[i]) begin
      m.put_byte(q[i], a);
      chk("data ack", 8'h0, a);
    end
    m.stop_c();
    repeat (20) @(posedge clk);
    chk("busy", 8'h1, {7'h0, busy});
    poll(dw(1'b0), 8'h1);
    for (int i = 0; i < PROG && busy === 1'b1; i++) @(posedge clk);
    chk("busy end", 8'h0, {7'h0, busy});
    poll(dw(1'b0), 8'h0);
  endtask
  // read n bytes into q, the last one unanswered; caller ends the frame
  task automatic rd(input logic [15:0] ad, input int n, input logic cur);
    if (!cur) set_addr(ad);
    m.start_c();
    m.put_byte(dw(1'b1), a);
    chk("rd ack", 8'h0, a);
    q = {};
    for (int i = 0; i < n; i++) begin
      m.get_byte(i == n - 1, b);
      q.push_back(b);
    end
  endtask
  task automatic t_select();
    for (int s = 0; s < 8; s++) poll({TC, s[2:0], 1'b0}, {7'h0, s[2:0] != straps});
    poll({TC ^ 4'h1, straps, 1'b0}, 8'h1);
  endtask
  task automatic t_write();
    q = {8'h3C};
    wr(16'h0123);
    rd(16'h0123, 1, 1'b0);
    m.stop_c();
    chk("byte", 8'h3C, q[0]);
    q = {8'h11, 8'h22, 8'h33};
    wr(16'h0FFE);
    rd(16'h0FFE, 2, 1'b0);
    m.stop_c();
    chk("seq0", 8'h11, q[0]);
    chk("seq1", 8'h22, q[1]);
    rd(16'h0FC0, 1, 1'b0);
    m.stop_c();
    chk("wrap", 8'h33, q[0]);
  endtask
  // upper eighth locked while protect high; lower area and reads still work
  task automatic t_protect();
    q = {8'hA5};
    wr(16'h7FFF);
    @(posedge clk) wp <= 1'b1;
    q = {8'h5A};
    wr(16'h7FFF);
    q = {8'hC0, 8'hC1};
    wr(16'h8000);
    rd(16'h7FFF, 2, 1'b0);
    m.stop_c();
    chk("locked", 8'hA5, q[0]);
    chk("rd wrap", 8'hC0, q[1]);
    rd(16'h0, 1, 1'b1);
    m.stop_c();
    chk("current", 8'hC1, q[0]);
    @(posedge clk) wp <= 1'b0;
  endtask
  // no answer and no stop: the line stays released
  task automatic t_hold();
    rd(16'h0123, 1, 1'b0);
    chk("hold", 8'h3C, q[0]);
    m.get_byte(1'b1, b);
    chk("released", 8'hFF, b);
    m.stop_c();
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk);
    t_select();
    @(posedge clk) straps <= 3'h2;
    t_select();
    t_write();
    t_protect();
    t_hold();
    results();
  end
endmodule // test_serial_eeprom_slave
`default_nettype wire
